// ---- include/rsp_pkg.sv ----
package rsp_pkg;
    // Bus address and direction
    localparam logic [6:0] DEV_ADDR     = 7'h68;
    localparam logic       DIR_WRITE    = 1'h0;
    localparam logic       DIR_READ     = 1'h1;
    // Counts
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam logic [7:0] PTR_RESET     = 8'h00;
    // Master clock: 10 MHz / (2*50) = 100 kHz
    localparam int         SYS_CLK_HZ    = 10000000;
    localparam int         SCL_HZ        = 100000;
    localparam logic [7:0] HALF_PERIOD   = 8'(SYS_CLK_HZ / (2 * SCL_HZ));
    localparam logic [7:0] QUARTER       = 8'(SYS_CLK_HZ / (4 * SCL_HZ));

    typedef enum logic [2:0] {
        SL_IDLE  = 3'h0,
        SL_ADDR  = 3'h1,
        SL_PTR   = 3'h2,
        SL_WDATA = 3'h3,
        SL_RDATA = 3'h4,
        SL_IGN   = 3'h5
    } rsp_slv_st_t;

    typedef enum logic [3:0] {
        MS_IDLE  = 4'h0,
        MS_START = 4'h1,
        MS_BIT   = 4'h2,
        MS_ACK   = 4'h3,
        MS_STOP  = 4'h4,
        MS_RSTA  = 4'h5,
        MS_DONE  = 4'h6
    } rsp_mst_st_t;
endpackage : rsp_pkg

// ---- include/rsp_bus_if.sv ----
`timescale 1ns/1ps
interface rsp_bus_if;
    // Master end
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    // Device end
    logic sda_s_o;
    logic sda_s_oe;
    // Resolved open-drain wires
    wire  scl = !(scl_oe && !scl_o);
    wire  sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport device (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : rsp_bus_if

// ---- hdl/rsp_sync.sv ----
`timescale 1ns/1ps
module rsp_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Pin in, synchronised out
    input  wire logic pin,
    output logic      sync
);
    logic meta_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 1'h1;
            sync     <= 1'h1;
        end else begin
            meta_reg <= pin;
            sync     <= meta_reg;
        end
    end
endmodule : rsp_sync

// ---- hdl/rsp_slave.sv ----
`timescale 1ns/1ps
module rsp_slave (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // Serial bus
    rsp_bus_if.device         bus,
    // Register side
    output logic              wr_stb,
    output logic [7:0]        wr_addr,
    output logic [7:0]        wr_data,
    output logic              rd_stb,
    output logic [7:0]        rd_addr,
    input  wire logic [7:0]   rd_data,
    output logic              busy
);
    logic                 scl_s, sda_s;
    logic                 scl_d_reg, sda_d_reg;
    rsp_pkg::rsp_slv_st_t st_reg, st_next;
    logic [3:0]           bit_reg;
    logic [7:0]           sh_reg;
    logic [7:0]           ptr_reg;
    logic [7:0]           tx_reg;
    logic                 drv_reg;
    logic                 ack_drv_reg;
    logic                 addr_hit_q;

    rsp_sync u_scl (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin(bus.scl), .sync(scl_s));
    rsp_sync u_sda (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin(bus.sda), .sync(sda_s));

    // Edge and condition decode
    wire scl_rise  = scl_s && !scl_d_reg;
    wire scl_fall  = !scl_s && scl_d_reg;
    wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    wire stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    wire in_ack    = (bit_reg == rsp_pkg::ACK_SLOT);
    wire [7:0] sh_in = {sh_reg[6:0], sda_s};
    wire byte_done = scl_rise && (bit_reg == rsp_pkg::BITS_PER_BYTE - 4'h1);
    wire addr_hit  = (sh_in[7:1] == rsp_pkg::DEV_ADDR);
    wire rx_state  = (st_reg == rsp_pkg::SL_ADDR) || (st_reg == rsp_pkg::SL_PTR)
                     || (st_reg == rsp_pkg::SL_WDATA);
    wire ack_rise  = scl_rise && in_ack;
    wire master_nak = ack_rise && (st_reg == rsp_pkg::SL_RDATA) && sda_s;

    // Next state
    always_comb begin
        st_next = st_reg;
        if (start_det) begin
            st_next = rsp_pkg::SL_ADDR;
        end else if (stop_det) begin
            st_next = rsp_pkg::SL_IDLE;
        end else if (byte_done && st_reg == rsp_pkg::SL_ADDR) begin
            if (!addr_hit) begin
                st_next = rsp_pkg::SL_IGN;
            end else if (sh_in[0] == rsp_pkg::DIR_READ) begin
                st_next = rsp_pkg::SL_RDATA;
            end else begin
                st_next = rsp_pkg::SL_PTR;
            end
        end else if (byte_done && st_reg == rsp_pkg::SL_PTR) begin
            st_next = rsp_pkg::SL_WDATA;
        end else if (master_nak) begin
            st_next = rsp_pkg::SL_IGN;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d_reg <= 1'h1;
            sda_d_reg <= 1'h1;
            st_reg    <= rsp_pkg::SL_IDLE;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            st_reg    <= st_next;
        end
    end

    // Bit counter and shifter
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_reg <= 4'h0;
            sh_reg  <= 8'h00;
        end else if (start_det) begin
            // The START's own falling clock wraps this to bit 0
            bit_reg <= 4'hf;
        end else if (scl_fall) begin
            bit_reg <= in_ack ? 4'h0 : bit_reg + 4'h1;
        end else if (scl_rise && !in_ack) begin
            sh_reg <= sh_in;
        end
    end

    // Pointer: never cleared by START
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg <= rsp_pkg::PTR_RESET;
        end else if (byte_done && st_reg == rsp_pkg::SL_PTR) begin
            ptr_reg <= sh_in;
        end else if (byte_done && st_reg == rsp_pkg::SL_WDATA) begin
            ptr_reg <= ptr_reg + 8'h01;
        end else if (ack_rise && st_reg == rsp_pkg::SL_RDATA && !addr_hit_q) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    // Register strobes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_stb  <= 1'h0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            rd_stb  <= 1'h0;
            rd_addr <= 8'h00;
            busy    <= 1'h0;
        end else begin
            wr_stb  <= byte_done && st_reg == rsp_pkg::SL_WDATA;
            wr_addr <= ptr_reg;
            wr_data <= sh_in;
            rd_stb  <= scl_fall && in_ack && st_next == rsp_pkg::SL_RDATA;
            rd_addr <= ptr_reg;
            busy    <= st_reg != rsp_pkg::SL_IDLE;
        end
    end

    // Data line drive, changed on falling clock and cleared on START or STOP
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_drv_reg <= 1'h0;
            drv_reg     <= 1'h0;
            tx_reg      <= 8'hff;
        end else if (start_det || stop_det) begin
            ack_drv_reg <= 1'h0;
            drv_reg     <= 1'h0;
        end else if (scl_fall) begin
            ack_drv_reg <= (bit_reg == rsp_pkg::BITS_PER_BYTE - 4'h1) && (addr_hit_q ||
                           (rx_state && st_reg != rsp_pkg::SL_ADDR));
            if (in_ack && st_reg == rsp_pkg::SL_RDATA) begin
                drv_reg <= 1'h1;
                tx_reg  <= rd_data;
            end else if (st_reg == rsp_pkg::SL_RDATA && !in_ack
                         && bit_reg != rsp_pkg::BITS_PER_BYTE - 4'h1) begin
                tx_reg  <= {tx_reg[6:0], 1'h1};
            end else begin
                drv_reg <= 1'h0;
            end
        end
    end

    // Address match held from the eighth rising edge through its ack slot
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_hit_q <= 1'h0;
        end else if (byte_done && st_reg == rsp_pkg::SL_ADDR) begin
            addr_hit_q <= addr_hit;
        end else if (scl_fall && in_ack) begin
            addr_hit_q <= 1'h0;
        end
    end

    // Never drives the clock; data low only when owed
    assign bus.sda_s_o  = 1'h0;
    assign bus.sda_s_oe = ack_drv_reg || (drv_reg && !tx_reg[7]);
endmodule : rsp_slave

// ---- hdl/rsp_master.sv ----
`timescale 1ns/1ps
module rsp_master (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // Serial bus
    rsp_bus_if.master         bus,
    // Command
    input  wire logic         cmd_go,
    input  wire logic         cmd_rd,
    input  wire logic         cmd_setptr,
    input  wire logic [7:0]   cmd_ptr,
    input  wire logic [7:0]   cmd_len,
    input  wire logic [7:0]   wr_data,
    output logic              wr_take,
    output logic              rd_valid,
    output logic [7:0]        rd_data,
    output logic              nak_seen,
    output logic              done
);
    rsp_pkg::rsp_mst_st_t st_reg;
    logic [7:0] div_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg, cnt_reg;
    logic [1:0] byte_kind_reg; // 0 addr, 1 ptr, 2 data
    logic       rd_mode_reg, sda_reg, scl_reg, sda_s;

    rsp_sync u_sda (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin(bus.sda), .sync(sda_s));

    // Quarter-bit enable from divider
    wire tick    = (div_reg == rsp_pkg::QUARTER - 8'h01);
    wire last_rd = rd_mode_reg && byte_kind_reg == 2'h2 && cnt_reg == 8'h01;
    wire want_rd = cmd_rd && !cmd_setptr;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= rsp_pkg::MS_IDLE; ph_reg <= 2'h0; bit_reg <= 4'h0;
            sh_reg <= 8'h00; cnt_reg <= 8'h00; byte_kind_reg <= 2'h0;
            rd_mode_reg <= 1'h0; sda_reg <= 1'h1; scl_reg <= 1'h1;
            wr_take <= 1'h0; rd_valid <= 1'h0; rd_data <= 8'h00;
            nak_seen <= 1'h0; done <= 1'h0;
        end else begin
            wr_take  <= 1'h0;
            rd_valid <= 1'h0;
            done     <= 1'h0;
            if (st_reg == rsp_pkg::MS_IDLE && cmd_go) begin
                st_reg <= rsp_pkg::MS_START; ph_reg <= 2'h0;
                rd_mode_reg <= want_rd; cnt_reg <= cmd_len; nak_seen <= 1'h0;
            end else if (tick) begin
                ph_reg <= ph_reg + 2'h1;
                case (st_reg)
                    rsp_pkg::MS_START, rsp_pkg::MS_RSTA: begin
                        // High-high-fall-low: start with clock high
                        if (ph_reg == 2'h0) begin sda_reg <= 1'h1; end
                        if (ph_reg == 2'h1) begin scl_reg <= 1'h1; end
                        if (ph_reg == 2'h2) begin sda_reg <= 1'h0; end
                        if (ph_reg == 2'h3) begin
                            scl_reg <= 1'h0; st_reg <= rsp_pkg::MS_BIT; bit_reg <= 4'h0;
                            byte_kind_reg <= 2'h0;
                            sh_reg <= {rsp_pkg::DEV_ADDR, rd_mode_reg};
                        end
                    end
                    rsp_pkg::MS_BIT: begin
                        if (ph_reg == 2'h0) begin
                            sda_reg <= (rd_mode_reg && byte_kind_reg == 2'h2) ? 1'h1 : sh_reg[7];
                        end
                        if (ph_reg == 2'h1) begin scl_reg <= 1'h1; end
                        if (ph_reg == 2'h2) begin sh_reg <= {sh_reg[6:0], sda_s}; end
                        if (ph_reg == 2'h3) begin
                            scl_reg <= 1'h0;
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg == rsp_pkg::BITS_PER_BYTE - 4'h1) begin st_reg <= rsp_pkg::MS_ACK; end
                        end
                    end
                    rsp_pkg::MS_ACK: begin
                        if (ph_reg == 2'h0) begin
                            sda_reg <= (rd_mode_reg && byte_kind_reg == 2'h2) ? last_rd : 1'h1;
                            if (rd_mode_reg && byte_kind_reg == 2'h2) begin
                                rd_data <= sh_reg; rd_valid <= 1'h1;
                            end
                        end
                        if (ph_reg == 2'h1) begin scl_reg <= 1'h1; end
                        if (ph_reg == 2'h2 && !(rd_mode_reg && byte_kind_reg == 2'h2) && sda_s) begin
                            nak_seen <= 1'h1;
                        end
                        if (ph_reg == 2'h3) begin
                            scl_reg <= 1'h0; bit_reg <= 4'h0;
                            if (nak_seen || (byte_kind_reg == 2'h2 && cnt_reg == 8'h01)
                                || (byte_kind_reg == 2'h1 && cmd_rd && cmd_setptr)
                                || (byte_kind_reg != 2'h0 && cnt_reg == 8'h00 && !rd_mode_reg)) begin
                                st_reg <= (cmd_rd && cmd_setptr && !rd_mode_reg && !nak_seen)
                                          ? rsp_pkg::MS_RSTA : rsp_pkg::MS_STOP;
                                rd_mode_reg <= cmd_rd && cmd_setptr && !rd_mode_reg;
                            end else begin
                                st_reg <= rsp_pkg::MS_BIT;
                                if (byte_kind_reg == 2'h0 && !rd_mode_reg) begin
                                    byte_kind_reg <= 2'h1; sh_reg <= cmd_ptr;
                                end else begin
                                    if (byte_kind_reg == 2'h2) begin cnt_reg <= cnt_reg - 8'h01; end
                                    byte_kind_reg <= 2'h2; sh_reg <= wr_data;
                                    wr_take <= !rd_mode_reg;
                                end
                            end
                        end
                    end
                    rsp_pkg::MS_STOP: begin
                        if (ph_reg == 2'h0) begin sda_reg <= 1'h0; end
                        if (ph_reg == 2'h1) begin scl_reg <= 1'h1; end
                        if (ph_reg == 2'h2) begin sda_reg <= 1'h1; end
                        if (ph_reg == 2'h3) begin st_reg <= rsp_pkg::MS_DONE; end
                    end
                    default: begin
                        st_reg <= rsp_pkg::MS_IDLE; done <= 1'h1; ph_reg <= 2'h0;
                    end
                endcase
            end
        end
    end

    assign bus.scl_o    = 1'h0;
    assign bus.scl_oe   = !scl_reg;
    assign bus.sda_m_o  = 1'h0;
    assign bus.sda_m_oe = !sda_reg;
endmodule : rsp_master

// ---- bench/rsp_bus_props.sv ----
`timescale 1ns/1ps
module rsp_bus_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Master drive
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    // Device drive
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    // Resolved lines
    input wire logic scl,
    input wire logic sda
);
    logic       scl_reg;
    logic       sda_reg;
    logic [3:0] pulse_reg;
    logic [7:0] byte_reg;
    logic [7:0] sh_reg;
    logic [1:0] mode_reg;
    logic       nak_reg;
    logic       idle_reg;
    // One cycle late is harmless at 25 cycles a phase
    wire        start_w    = scl && scl_reg && sda_reg && !sda;
    wire        stop_w     = scl && scl_reg && !sda_reg && sda;
    wire        rise_w     = scl && !scl_reg;
    wire        ninth_w    = rise_w && pulse_reg == 4'h7;
    wire        match_w    = sh_reg[7:1] == rsp_pkg::DEV_ADDR;
    wire [3:0]  pulse_next = (pulse_reg == 4'h8 || pulse_reg == 4'hf) ? 4'h0 : pulse_reg + 4'h1;
    // Mode 1 write, 2 read, 3 foreign
    wire [1:0]  mode_next  = !match_w ? 2'h3 : (sh_reg[0] ? 2'h2 : 2'h1);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_reg <= 1'h1;
            sda_reg <= 1'h1;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst || start_w) begin
            pulse_reg <= 4'hf;
            byte_reg  <= 8'h00;
        end else if (rise_w) begin
            pulse_reg <= pulse_next;
            byte_reg  <= byte_reg + 8'(pulse_reg == 4'h8);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rise_w) begin
            sh_reg <= {sh_reg[6:0], sda};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= 2'h0;
            nak_reg  <= 1'h0;
            idle_reg <= 1'h1;
        end else begin
            mode_reg <= (start_w || stop_w) ? 2'h0 : ((ninth_w && byte_reg == 8'h00) ? mode_next : mode_reg);
            nak_reg  <= (nak_reg || (ninth_w && mode_reg == 2'h2 && sda)) && !start_w && !stop_w;
            idle_reg <= (idle_reg || stop_w) && !start_w;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    property p_sda_steady; scl && scl_reg |-> $stable(sda_s_oe); endproperty
    a_sda_steady: assert property (p_sda_steady) else $error("device data moved with clock high");
    property p_addr_bits; ninth_w && byte_reg == 8'h00 |-> match_w; endproperty
    a_addr_bits: assert property (p_addr_bits) else $error("address byte wrong or out of order");
    property p_addr_ack; ninth_w && byte_reg == 8'h00 && match_w |-> !sda; endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
    property p_ack_hold; ninth_w && !sda |=> (!sda) [*8]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held low");
    property p_wr_ack; ninth_w && mode_reg == 2'h1 |-> !sda; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
    property p_rd_owner;
        rise_w && mode_reg == 2'h2 && pulse_reg != 4'h7 && !nak_reg |-> !(sda_m_oe && !sda_m_o);
    endproperty
    a_rd_owner: assert property (p_rd_owner) else $error("master drove a read data bit");
    property p_nak_release; nak_reg |-> !sda_s_oe; endproperty
    a_nak_release: assert property (p_nak_release) else $error("device drove after not-acknowledge");
    property p_idle_release; idle_reg |-> !sda_s_oe; endproperty
    a_idle_release: assert property (p_idle_release) else $error("device drove an idle bus");
endmodule : rsp_bus_props

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic            sys_clk;
    logic            sys_rst;
    logic            cmd_go;
    logic            cmd_rd;
    logic            cmd_setptr;
    logic [7:0]      cmd_ptr;
    logic [7:0]      cmd_len;
    wire logic [7:0] m_wdata;
    logic            wr_take;
    logic            rd_valid;
    logic [7:0]      m_rdata;
    logic            nak_seen;
    logic            done;
    logic            wr_stb;
    logic [7:0]      wr_addr;
    logic [7:0]      wr_data;
    logic [7:0]      rd_addr;
    logic [7:0]      regs_mem [256];
    logic [7:0]      wbuf [4];
    logic [1:0]      wi;
    logic [7:0]      rq [$];
    int              errors;
    int              checks;

    rsp_bus_if bus_if ();
    rsp_master rsp_master_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if.master), .cmd_go(cmd_go),
        .cmd_rd(cmd_rd), .cmd_setptr(cmd_setptr), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_data(m_wdata),
        .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(m_rdata), .nak_seen(nak_seen), .done(done));
    rsp_slave rsp_slave_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if.device), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(), .rd_addr(rd_addr), .rd_data(regs_mem[rd_addr]), .busy());
    rsp_bus_props rsp_bus_props_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_o(bus_if.scl_o),
        .scl_oe(bus_if.scl_oe), .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
        .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    assign m_wdata = wbuf[wi];

    // Register file behind the device; no wait states
    always @(posedge sys_clk) begin
        if (wr_stb) begin
            regs_mem[wr_addr] <= wr_data;
        end
        if (wr_take) begin
            wi <= wi + 2'h1;
        end
        if (rd_valid) begin
            rq.push_back(m_rdata);
        end
    end

    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction : pat

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic xfer(input logic rd, input logic sp, input logic [7:0] ptr, input logic [7:0] len);
        int n;
        n = 0;
        rq.delete();
        @(posedge sys_clk);
        cmd_rd     <= rd;
        cmd_setptr <= sp;
        cmd_ptr    <= ptr;
        cmd_len    <= len;
        cmd_go     <= 1'b1;
        wi         <= 2'h0;
        @(posedge sys_clk);
        cmd_go <= 1'b0;
        // Sampled on the falling edge, clear of the edge that raises done
        while (done !== 1'b1 && n < 9000) begin
            @(negedge sys_clk);
            n++;
        end
        chk("done", {7'h00, done}, 8'h01);
    endtask : xfer

    task automatic rd_chk(input logic sp, input logic [7:0] ptr, input logic [7:0] len, input logic [7:0] first);
        xfer(1'b1, sp, ptr, len);
        chk("count", 8'(rq.size()), len);
        for (int i = 0; i < rq.size(); i++) begin
            chk("byte", rq[i], pat(first + 8'(i)));
        end
    endtask : rd_chk

    // Pointer from reset, a write that wraps the pointer, a read where it stopped
    task automatic t_write_wrap;
        rd_chk(1'b0, 8'h00, 8'h01, rsp_pkg::PTR_RESET);
        @(posedge sys_clk);
        wbuf <= '{8'ha1, 8'hb2, 8'hc3, 8'h00};
        xfer(1'b0, 1'b0, 8'hfe, 8'h03);
        chk("reg_fe", regs_mem[8'hfe], 8'ha1);
        chk("reg_ff", regs_mem[8'hff], 8'hb2);
        chk("reg_00", regs_mem[8'h00], 8'hc3);
        chk("nak", {7'h00, nak_seen}, 8'h00);
        rd_chk(1'b0, 8'h00, 8'h02, 8'h01);
    endtask : t_write_wrap

    // Pointer-only write, then reads with and without a repeated start
    task automatic t_rstart;
        xfer(1'b0, 1'b0, 8'h40, 8'h00);
        rd_chk(1'b0, 8'h00, 8'h01, 8'h40);
        rd_chk(1'b1, 8'h10, 8'h03, 8'h10);
        rd_chk(1'b0, 8'h00, 8'h01, 8'h13);
    endtask : t_rstart

    task automatic results;
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Whole run needs about 21500 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        results();
    end

    initial begin
        sys_rst    = 1'b1;
        cmd_go     = 1'b0;
        cmd_rd     = 1'b0;
        cmd_setptr = 1'b0;
        cmd_ptr    = 8'h00;
        cmd_len    = 8'h00;
        wi         = 2'h0;
        errors     = 0;
        checks     = 0;
        for (int i = 0; i < 256; i++) begin
            regs_mem[i] = pat(8'(i));
        end
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_write_wrap();
        t_rstart();
        results();
    end
endmodule : testbench
